/* File: rtl/clamp_output_sequencer.sv */
// Clamp output sequencer: division-2 stepping, toggles, two-step clamp
//
// Functional notes
// - Step-on press turns on next clamp in order 5, 6, 7, 8.
// - Step-off press turns off one clamp in order 8, 7, 6, 5.
// - Step-off ignored when block division is none or four.
// - Step-off ignored when division-2 valid clamp count is one.
// - While clear-all is held, every clamp output is off.
// - Two-step switch acts only while the two-step setting is on.
// - Two-step presses select low, then high, then release output.
// - After release, the next press restarts at low, endlessly.
// - Each toggle press inverts its own clamp output.
`timescale 1ns/1ps
`default_nettype none
module clamp_output_sequencer #(
  parameter int DEB_CYCLES = clamp_pkg::DEBOUNCE_CYCLES
) (
  input  wire logic                            sys_clk,
  input  wire logic                            rst_b,
  input  wire logic                            div2_step_on_in,
  input  wire logic                            div2_step_off_in,
  input  wire logic                            clear_all_clamps_in,
  input  wire logic                            two_step_switch_in,
  input  wire logic [clamp_pkg::NUM_CLAMPS-1:0] clamp_toggle_in,
  input  wire logic [2:0]                      block_division_setting,
  input  wire logic [2:0]                      div2_valid_clamp_count,
  input  wire logic                            two_step_enable_setting,
  output logic      [clamp_pkg::NUM_CLAMPS-1:0] clamp_out,
  output logic                                 pneumatic_low_out,
  output logic                                 pneumatic_high_out,
  output logic                                 pneumatic_release_out
);
  import clamp_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [NUM_EDGES-1:0]  pulses;
  logic                  on_p;
  logic                  off_p;
  logic                  two_p;
  logic [NUM_CLAMPS-1:0] tog_p;
  logic                  off_blocked;
  logic [NUM_CLAMPS-1:0] clamp_r;
  logic [NUM_CLAMPS-1:0] clamp_nxt;
  logic [2:0]            step_r;
  logic [2:0]            step_nxt;
  logic [2:0]            idx;
  pneu_state_t           pn_r;
  pneu_state_t           pn_nxt;
  logic                  low_r;
  logic                  low_nxt;
  logic                  high_r;
  logic                  high_nxt;
  logic                  rel_r;
  logic                  rel_nxt;

  // ----------------------------------------------------------------
  // Switch conditioning
  // ----------------------------------------------------------------
  // Clear-all is a level and needs no edge; the rest are presses
  edge_debounce #(
    .W   (NUM_EDGES),
    .DEB (DEB_CYCLES)
  ) u_deb (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .raw     ({clamp_toggle_in, two_step_switch_in,
               div2_step_off_in, div2_step_on_in}),
    .pulse   (pulses)
  );

  assign on_p  = pulses[0];
  assign off_p = pulses[1];
  assign two_p = pulses[2];
  assign tog_p = pulses[NUM_EDGES-1:3];

  // Step-off lockout from the stored settings
  assign off_blocked = (block_division_setting == DIV_NONE)
                    || (block_division_setting == DIV_FOUR)
                    || (div2_valid_clamp_count == ONE_CLAMP);

  // ----------------------------------------------------------------
  // Clamp outputs and division-2 step pointer
  // ----------------------------------------------------------------
  // Toggles first, then stepping, clear-all last so it always wins.
  // The pointer tracks only stepping; a toggle on 5..8 is not seen by it.
  always_comb begin
    clamp_nxt = clamp_r ^ tog_p;
    step_nxt  = step_r;
    idx       = DIV2_BASE + step_r;
    if (on_p && (step_r < DIV2_SLOTS)) begin
      clamp_nxt[idx] = 1'b1;
      step_nxt       = step_r + 3'h1;
    end else if (off_p && !off_blocked && (step_r != STEP_RST)) begin
      idx            = DIV2_BASE + step_r - 3'h1;
      clamp_nxt[idx] = 1'b0;
      step_nxt       = step_r - 3'h1;
    end
    if (clear_all_clamps_in) begin
      clamp_nxt = CLAMP_RST;
      step_nxt  = STEP_RST;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      clamp_r <= CLAMP_RST;
      step_r  <= STEP_RST;
    end else begin
      clamp_r <= clamp_nxt;
      step_r  <= step_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Two-step pneumatic clamp cycle
  // ----------------------------------------------------------------
  // One valve at a time, so low and high never fight each other
  always_comb begin
    pn_nxt = pn_r;
    if (two_p && two_step_enable_setting) begin
      case (pn_r)
        PN_IDLE: pn_nxt = PN_LOW;
        PN_LOW:  pn_nxt = PN_HIGH;
        PN_HIGH: pn_nxt = PN_REL;
        PN_REL:  pn_nxt = PN_LOW;
        default: pn_nxt = PN_IDLE;
      endcase
    end
    low_nxt  = (pn_nxt == PN_LOW);
    high_nxt = (pn_nxt == PN_HIGH);
    rel_nxt  = (pn_nxt == PN_REL);
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pn_r   <= PN_IDLE;
      low_r  <= 1'b0;
      high_r <= 1'b0;
      rel_r  <= 1'b0;
    end else begin
      pn_r   <= pn_nxt;
      low_r  <= low_nxt;
      high_r <= high_nxt;
      rel_r  <= rel_nxt;
    end
  end

  assign clamp_out             = clamp_r;
  assign pneumatic_low_out     = low_r;
  assign pneumatic_high_out    = high_r;
  assign pneumatic_release_out = rel_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  chk_step_on_first: assert property (
    on_p && step_r == STEP_RST && !clear_all_clamps_in && tog_p == '0
    |=> clamp_out[4] && step_r == 3'h1)
    else $error("step-on did not turn on clamp five");

  chk_step_off_last: assert property (
    off_p && !on_p && !off_blocked && step_r == DIV2_SLOTS
    && !clear_all_clamps_in && tog_p == '0
    |=> !clamp_out[7] && clamp_out[6] == $past(clamp_out[6]))
    else $error("step-off did not turn off clamp eight only");

  chk_off_div_lock: assert property (
    off_p && !on_p && tog_p == '0 && !clear_all_clamps_in
    && (block_division_setting == DIV_NONE
        || block_division_setting == DIV_FOUR)
    |=> $stable(clamp_out) && $stable(step_r))
    else $error("step-off acted under division lockout");

  chk_off_one_lock: assert property (
    off_p && !on_p && tog_p == '0 && !clear_all_clamps_in
    && div2_valid_clamp_count == ONE_CLAMP
    |=> $stable(clamp_out))
    else $error("step-off acted with one valid clamp");

  chk_clear_all_off: assert property (
    clear_all_clamps_in [*2] |=> clamp_out == '0 && step_r == STEP_RST)
    else $error("clamps not cleared while clear-all held");

  chk_two_step_gate: assert property (
    !two_step_enable_setting |=> $stable(pn_r))
    else $error("two-step cycle moved while disabled");

  chk_two_step_order: assert property (
    two_p && two_step_enable_setting && pn_r == PN_LOW
    |=> pneumatic_high_out && !pneumatic_low_out && !pneumatic_release_out)
    else $error("second press did not select high pressure");

  chk_two_step_wrap: assert property (
    two_p && two_step_enable_setting && pn_r == PN_REL
    |=> pneumatic_low_out && !pneumatic_release_out)
    else $error("cycle did not restart at low pressure");

  chk_toggle_invert: assert property (
    tog_p[0] && !clear_all_clamps_in
    |=> clamp_out[0] != $past(clamp_out[0]))
    else $error("toggle did not invert clamp one");

  chk_single_pulse: assert property (
    on_p |=> !on_p [*2])
    else $error("held step-on produced more than one step");

  cov_step_fill: cover property (
    clamp_out[7:4] == 4'hf ##1 off_p);
  cov_two_step_loop: cover property (
    pn_r == PN_REL ##[1:1000] pn_r == PN_LOW);
  cov_clear_all: cover property (
    clamp_out != '0 ##1 clear_all_clamps_in);
endmodule
`default_nettype wire

/* File: rtl/clamp_pkg.sv */
// Constants and types shared by the clamp output sequencer
package clamp_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ         = 200;
  localparam int DEBOUNCE_US     = 5;
  localparam int DEBOUNCE_CYCLES = DEBOUNCE_US * CLK_MHZ;

  // ----------------------------------------------------------------
  // Clamp layout and settings
  // ----------------------------------------------------------------
  localparam int       NUM_CLAMPS = 8;
  localparam int       NUM_EDGES  = 11;
  localparam logic [2:0] DIV2_BASE  = 3'h4;
  localparam logic [2:0] DIV2_SLOTS = 3'h4;
  localparam logic [2:0] DIV_NONE   = 3'h0;
  localparam logic [2:0] DIV_FOUR   = 3'h4;
  localparam logic [2:0] ONE_CLAMP  = 3'h1;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CLAMP_RST = 8'h00;
  localparam logic [2:0] STEP_RST  = 3'h0;

  // ----------------------------------------------------------------
  // Two-step pneumatic cycle
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    PN_IDLE = 4'h1,
    PN_LOW  = 4'h2,
    PN_HIGH = 4'h4,
    PN_REL  = 4'h8
  } pneu_state_t;

endpackage

/* File: rtl/edge_debounce.sv */
// Synchroniser, debouncer and rising-edge pulse for a group of switches
`timescale 1ns/1ps
`default_nettype none
module edge_debounce #(
  parameter int W   = 11,
  parameter int DEB = 1000
) (
  input  wire logic         sys_clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] raw,
  output logic      [W-1:0] pulse
);
  localparam int CW = $clog2(DEB + 1);

  logic [W-1:0]  meta_r;
  logic [W-1:0]  sync_r;
  logic [W-1:0]  stable_r;
  logic [W-1:0]  stable_nxt;
  logic [W-1:0]  pulse_r;
  logic [W-1:0]  pulse_nxt;
  logic [CW-1:0] cnt_r   [W];
  logic [CW-1:0] cnt_nxt [W];

  // ----------------------------------------------------------------
  // Debounce: a change must hold DEB cycles before it is accepted
  // ----------------------------------------------------------------
  always_comb begin
    stable_nxt = stable_r;
    pulse_nxt  = '0;
    for (int i = 0; i < W; i++) begin
      cnt_nxt[i] = '0;
      if (sync_r[i] != stable_r[i]) begin
        if (cnt_r[i] == CW'(DEB - 1)) begin
          stable_nxt[i] = sync_r[i];
          // Only the off-to-on change counts, once per press
          pulse_nxt[i]  = sync_r[i];
        end else begin
          cnt_nxt[i] = cnt_r[i] + CW'(1);
        end
      end
    end
  end

  // Registers; meta_r feeds only sync_r
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_r   <= '0;
      sync_r   <= '0;
      stable_r <= '0;
      pulse_r  <= '0;
      for (int i = 0; i < W; i++) begin
        cnt_r[i] <= '0;
      end
    end else begin
      meta_r   <= raw;
      sync_r   <= meta_r;
      stable_r <= stable_nxt;
      pulse_r  <= pulse_nxt;
      for (int i = 0; i < W; i++) begin
        cnt_r[i] <= cnt_nxt[i];
      end
    end
  end

  assign pulse = pulse_r;
endmodule
`default_nettype wire

/* File: bench/switch_panel.sv */
// Operator switch panel model driving the raw switch lines
`timescale 1ns/1ps
`default_nettype none
module switch_panel (
  input  wire logic        sys_clk,
  output logic      [10:0] sw
);
  // All switches rest released; bits 0-7 toggles, 8 on, 9 off, 10 two-step
  initial sw = 11'h000;

  // One press, held well past debounce, then a re-arming release
  task automatic press(input int idx, input int hold);
    @(negedge sys_clk);
    sw[idx] = 1'b1;
    repeat (hold) @(negedge sys_clk);
    sw[idx] = 1'b0;
    repeat (12) @(negedge sys_clk);
  endtask
endmodule
`default_nettype wire

/* File: bench/clamp_output_sequencer_test.sv */
// Self-checking bench for the clamp output sequencer
`timescale 1ns/1ps
`default_nettype none
module clamp_output_sequencer_test;
  import clamp_pkg::*;
  logic        sys_clk = 1'b0;
  logic        rst_b   = 1'b0;
  logic        clr     = 1'b0;
  logic [2:0]  blk     = 3'h2;
  logic [2:0]  cnt     = 3'h4;
  logic        en      = 1'b0;
  logic [10:0] sw;
  logic [7:0]  clamp_out;
  logic        lo;
  logic        hi;
  logic        rel;
  logic [10:0] exp;
  int          err_count = 0;
  int          tests_run = 0;
  wire  [10:0] seen = {rel, hi, lo, clamp_out};

  // 200 MHz clock
  always #2.5 sys_clk = ~sys_clk;

  switch_panel switch_panel_i (.sys_clk(sys_clk), .sw(sw));

  // Short debounce keeps each press to a few dozen cycles
  clamp_output_sequencer #(.DEB_CYCLES(4)) clamp_output_sequencer_i (
    .sys_clk                (sys_clk),
    .rst_b                  (rst_b),
    .div2_step_on_in        (sw[8]),
    .div2_step_off_in       (sw[9]),
    .clear_all_clamps_in    (clr),
    .two_step_switch_in     (sw[10]),
    .clamp_toggle_in        (sw[7:0]),
    .block_division_setting (blk),
    .div2_valid_clamp_count (cnt),
    .two_step_enable_setting(en),
    .clamp_out              (clamp_out),
    .pneumatic_low_out      (lo),
    .pneumatic_high_out     (hi),
    .pneumatic_release_out  (rel)
  );

  // ------------------------------------------------------------
  // Shared helpers
  // ------------------------------------------------------------
  task automatic check(input logic [10:0] got, input logic [10:0] want);
    tests_run++;
    if (got !== want) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, got, want);
    end
  endtask

  task automatic p(input int idx);
    switch_panel_i.press(idx, 12);
  endtask

  task automatic close_out;
    $display("tests_run=%0d err_count=%0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  // Five presses each way: the fifth must be refused at the ends
  task automatic t_step;
    exp = 11'h000;
    for (int n = 0; n < 5; n++) begin
      p(8);
      if (n < 4) exp[4+n] = 1'b1;
      check(seen, exp);
    end
    for (int n = 0; n < 5; n++) begin
      p(9);
      if (n < 4) exp[7-n] = 1'b0;
      check(seen, exp);
    end
    $display("step test done");
  endtask

  // Each blocking setting freezes step-off, then a legal one frees it
  task automatic t_block;
    logic [5:0] tbl [3] = '{6'o04, 6'o44, 6'o21};
    for (int k = 0; k < 3; k++) begin
      @(negedge sys_clk);
      {blk, cnt} = tbl[k];
      p(8);
      p(9);
      check(seen, 11'h010);
      @(negedge sys_clk);
      {blk, cnt} = 6'o24;
      p(9);
      check(seen, 11'h000);
    end
    $display("block test done");
  endtask

  // Every toggle on then off; the off press is held very long
  task automatic t_toggle;
    for (int i = 0; i < 8; i++) begin
      p(i);
      check(seen, 11'h001 << i);
      switch_panel_i.press(i, 40);
      check(seen, 11'h000);
    end
    $display("toggle test done");
  endtask

  // Clear-all forces every clamp off while held
  task automatic t_clear;
    p(0);
    p(7);
    // Both clamps must be on first, or the clear proves nothing
    check(seen, 11'h081);
    @(negedge sys_clk);
    clr = 1'b1;
    repeat (3) @(negedge sys_clk);
    check(seen, 11'h000);
    clr = 1'b0;
    repeat (3) @(negedge sys_clk);
    check(seen, 11'h000);
    $display("clear test done");
  endtask

  // Two-step cycle gated by its setting, then reset mid-cycle
  task automatic t_pneu;
    p(10);
    check(seen, 11'h000);
    en = 1'b1;
    for (int n = 0; n < 7; n++) begin
      p(10);
      check(seen, 11'h100 << (n % 3));
    end
    p(8);
    // Low stage and first step both on before the mid-run reset
    check(seen, 11'h110);
    rst_b = 1'b0;
    repeat (2) @(negedge sys_clk);
    check(seen, 11'h000);
    rst_b = 1'b1;
    p(10);
    p(8);
    check(seen, 11'h110);
    $display("pneumatic test done");
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (10) @(negedge sys_clk);
    check(seen, 11'h000);
    rst_b = 1'b1;
    repeat (2) @(negedge sys_clk);
    t_step();
    t_block();
    t_toggle();
    t_clear();
    t_pneu();
    close_out();
  end
endmodule
`default_nettype wire
